/* File: verilog/mab_pkg.sv */
// Constants, field layouts and helper functions of the muxed bus interface
// Functional notes
// - Bus multiplexed; address phase marked by latch strobe
// - Address phase drives address bits 31:4
// - Address phase drives byte strobes on bits 3:0
// - Config bit holds strobes inactive on reads
// - Second phase bus carries data only
// - Writes drive data from write buffer
// - Reads capture one datum or four words
// - Lanes follow size, port width, byte order
// - Separate four-line low address output driven
// - Valid low bits depend on port width
// - Writes/single reads: exact address, then increment
// - Burst reads count from zero by port step
// - Low lines are option inputs during reset
// - Diagnostic pin multiplexed within each read
// - Address phase: diagnostic high on cache miss
// - Later phase: diagnostic high for instruction
package mab_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL  = 6'h00;
   localparam logic [5:0] OFS_ADDR  = 6'h04;
   localparam logic [5:0] OFS_WDATA = 6'h08;
   localparam logic [5:0] OFS_CMD   = 6'h0c;
   localparam logic [5:0] OFS_STAT  = 6'h10;
   localparam logic [5:0] OFS_RBUF  = 6'h20;
   // Control fields
   localparam int CTRL_HOLD_BIT = 0;
   localparam int CTRL_BIG_BIT  = 1;
   // Command fields
   localparam int CMD_KIND_LSB  = 0;
   localparam int CMD_SIZE_LSB  = 2;
   localparam int CMD_PORT_LSB  = 4;
   localparam int CMD_INSTR_BIT = 6;
   localparam int CMD_MISS_BIT  = 7;
   // Status fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_STRAP_LSB = 4;
   // Transfer kinds
   localparam logic [1:0] KIND_WRITE  = 2'h0;
   localparam logic [1:0] KIND_SINGLE = 2'h1;
   localparam logic [1:0] KIND_BURST  = 2'h2;
   // Port width codes
   localparam logic [1:0] PORT_32 = 2'h0;
   localparam logic [1:0] PORT_16 = 2'h1;
   localparam logic [1:0] PORT_8  = 2'h2;
   // Log2 of bytes in a burst and in a word
   localparam logic [2:0] BURST_LOG = 3'h4;
   localparam logic [1:0] WORD_LOG  = 2'h2;
   localparam logic [3:0] ALL_OFF   = 4'hf;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} mab_state_t;

   // Log2 of bytes carried by a port
   function automatic logic [1:0] mab_plog(input logic [1:0] port);
      mab_plog = (port == PORT_16) ? 2'h1 : (port == PORT_8) ? 2'h0 : WORD_LOG;
   endfunction

   // Byte lane mask of an item of 2**slog bytes at address a
   function automatic logic [3:0] mab_lanes(input logic [1:0] slog, input logic [1:0] a,
                                             input logic big);
      logic [2:0] nb;
      logic [2:0] off;
      logic [2:0] sh;
      nb  = 3'h1 << slog;
      off = {1'b0, a & ~(nb[1:0] - 2'h1)};
      sh  = big ? (3'h4 - nb - off) : off;
      mab_lanes = 4'((5'h1 << nb) - 5'h1) << sh;
   endfunction
endpackage

/* File: verilog/mab_bus_if.sv */
// Muxed address/data bus interface with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module mab_bus_if
   import mab_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_I,
   // Avalon-MM slave
   input  wire logic [5:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output logic      [31:0] AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   // Multiplexed address/data bus
   input  wire logic [31:0] AD_I,
   output logic      [31:0] AD_O,
   output logic             AD_OE_O,
   output logic             ALE_O,
   // Low address lines and reset options
   input  wire logic [3:0]  LADDR_I,
   output logic      [3:0]  LADDR_O,
   output logic             LADDR_OE_O,
   // Miss diagnostic
   output logic             DIAG_O
);
   mab_state_t  state_ff;
   logic [1:0]  ctrl_ff;
   logic [31:0] addr_ff;
   logic [31:0] wdata_ff;
   logic [7:0]  cmd_ff;
   logic [31:0] rbuf_ff [4];
   logic [3:0]  low_ff;
   logic [4:0]  beats_ff;
   logic        ack_ff;
   logic [3:0]  strap_ff;
   logic [31:0] rdata_ff;

   // Register access decode
   wire         req       = AVS_READ_I | AVS_WRITE_I;
   wire         busy      = (state_ff != ST_IDLE);
   wire         cmd_hit   = (AVS_ADDRESS_I == OFS_CMD);
   wire         cmd_stall = AVS_WRITE_I & cmd_hit & busy;
   wire         take      = req & ack_ff & ~cmd_stall;
   wire         wr_take   = take & AVS_WRITE_I;
   wire         start     = wr_take & cmd_hit;
   assign AVS_WAITREQUEST_O = req & ~take;
   assign AVS_READDATA_O    = rdata_ff;

   // Fields of the active (or arriving) command
   wire [7:0]   cmd_src = start ? AVS_WRITEDATA_I[7:0] : cmd_ff;
   wire [1:0]   kind    = cmd_src[CMD_KIND_LSB +: 2];
   wire [1:0]   size_raw = cmd_src[CMD_SIZE_LSB +: 2];
   wire [1:0]   slog    = (size_raw > WORD_LOG) ? WORD_LOG : size_raw; // Wider sizes act as a word
   wire [1:0]   plog    = mab_plog(cmd_src[CMD_PORT_LSB +: 2]);
   wire         is_rd   = (kind != KIND_WRITE);
   wire         burst   = (kind == KIND_BURST);
   wire         big     = ctrl_ff[CTRL_BIG_BIT];
   wire [3:0]   step    = 4'h1 << plog;
   wire [3:0]   vmask   = 4'(ALL_OFF << plog);
   wire [2:0]   xlog    = burst ? BURST_LOG : {1'b0, slog};
   wire [4:0]   nbeats  = (xlog > {1'b0, plog}) ? 5'(5'h1 << (xlog - {1'b0, plog})) : 5'h1;
   wire [3:0]   lanes   = mab_lanes(slog, addr_ff[1:0], big);
   wire [3:0]   strobes = (is_rd & ctrl_ff[CTRL_HOLD_BIT]) ? ALL_OFF : ~lanes;
   wire [3:0]   pmask   = mab_lanes(plog, low_ff[1:0], big);
   wire [31:0]  bmask   = {{8{pmask[3]}}, {8{pmask[2]}}, {8{pmask[1]}}, {8{pmask[0]}}};
   wire         in_addr = (state_ff == ST_ADDR);
   wire         in_data = (state_ff == ST_DATA);
   wire         rd_cmd  = (cmd_ff[CMD_KIND_LSB +: 2] != KIND_WRITE); // Direction of the running transfer
   // Tap for the read capture check
   wire [7:0]   ad_lane0 = AD_I[7:0];

   // Register read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (AVS_ADDRESS_I)
         OFS_CTRL:  rd_mux = {30'h0, ctrl_ff};
         OFS_ADDR:  rd_mux = addr_ff;
         OFS_WDATA: rd_mux = wdata_ff;
         OFS_CMD:   rd_mux = {24'h0, cmd_ff};
         OFS_STAT: begin
            rd_mux[STAT_BUSY_BIT]       = busy;
            rd_mux[STAT_STRAP_LSB +: 4] = strap_ff;
         end
         default: begin
            if (AVS_ADDRESS_I[5:4] == OFS_RBUF[5:4])
               rd_mux = rbuf_ff[AVS_ADDRESS_I[3:2]];
         end
      endcase
   end

   // Pin drive: address phase then data phase
   assign ALE_O      = in_addr;
   assign AD_OE_O    = in_addr | (in_data & ~is_rd);
   assign AD_O       = in_addr ? {addr_ff[31:4], strobes} : wdata_ff;
   assign LADDR_O    = low_ff & vmask;
   assign LADDR_OE_O = ~RST_I;
   assign DIAG_O     = rd_cmd & (in_addr ? cmd_ff[CMD_MISS_BIT] : in_data & cmd_ff[CMD_INSTR_BIT]);

   // Option straps caught while reset is held
   always_ff @(posedge MCLK_I) begin
      if (RST_I)
         strap_ff <= LADDR_I;
   end

   // Avalon handshake and register writes
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
         ctrl_ff  <= 2'h0;
         addr_ff  <= 32'h0;
         wdata_ff <= 32'h0;
         cmd_ff   <= 8'h0;
      end else begin
         ack_ff   <= req & ~take;
         rdata_ff <= rd_mux;
         if (wr_take && AVS_ADDRESS_I == OFS_CTRL)
            ctrl_ff <= AVS_WRITEDATA_I[1:0];
         if (wr_take && AVS_ADDRESS_I == OFS_ADDR)
            addr_ff <= AVS_WRITEDATA_I;
         if (wr_take && AVS_ADDRESS_I == OFS_WDATA)
            wdata_ff <= AVS_WRITEDATA_I;
         if (start)
            cmd_ff <= AVS_WRITEDATA_I[7:0];
      end
   end

   // Transfer sequencer
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_ff <= ST_IDLE;
         low_ff   <= 4'h0;
         beats_ff <= 5'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  state_ff <= ST_ADDR;
                  low_ff   <= burst ? 4'h0 : addr_ff[3:0];
                  beats_ff <= nbeats - 5'h1;
               end
            end
            ST_ADDR: begin
               state_ff <= ST_DATA;
            end
            ST_DATA: begin
               if (beats_ff == 5'h0) begin
                  state_ff <= ST_IDLE;
               end else begin
                  beats_ff <= beats_ff - 5'h1;
                  low_ff   <= low_ff + step;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Read buffer capture, lane by lane
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (int i = 0; i < 4; i++)
            rbuf_ff[i] <= 32'h0;
      end else if (in_data && is_rd) begin
         rbuf_ff[low_ff[3:2]] <= (rbuf_ff[low_ff[3:2]] & ~bmask) | (AD_I & bmask);
      end
   end

   // Checks
   property p_addr_phase;
      @(posedge MCLK_I) disable iff (RST_I)
         ALE_O |-> AD_OE_O && AD_O[31:4] == addr_ff[31:4] ##1 !ALE_O;
   endproperty
   a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");

   property p_strobes;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && !is_rd) |-> AD_O[3:0] == ~mab_lanes(slog, addr_ff[1:0], big);
   endproperty
   a_strobes: assert property (p_strobes) else $error("byte strobes wrong");

   property p_hold;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && is_rd && ctrl_ff[CTRL_HOLD_BIT]) |-> AD_O[3:0] == ALL_OFF;
   endproperty
   a_hold: assert property (p_hold) else $error("strobes not held on read");

   property p_wdata;
      @(posedge MCLK_I) disable iff (RST_I)
         (in_data && !is_rd) |-> AD_OE_O && AD_O == wdata_ff;
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data not driven");

   property p_rd_release;
      @(posedge MCLK_I) disable iff (RST_I)
         $rose(in_data) && is_rd |-> !AD_OE_O throughout (in_data [*1]);
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus driven on read");

   property p_burst_zero;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && burst) |=> LADDR_O == 4'h0 ##3 !in_data || LADDR_O != 4'h0;
   endproperty
   a_burst_zero: assert property (p_burst_zero) else $error("burst count bad");

   property p_step;
      @(posedge MCLK_I) disable iff (RST_I)
         (in_data && beats_ff != 5'h0) |=> low_ff == $past(low_ff) + $past(step);
   endproperty
   a_step: assert property (p_step) else $error("low address step wrong");

   property p_valid_bits;
      @(posedge MCLK_I) disable iff (RST_I)
         busy |-> (LADDR_O & ~vmask) == 4'h0;
   endproperty
   a_valid_bits: assert property (p_valid_bits) else $error("invalid low bits driven");

   property p_diag_miss;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && is_rd) |-> DIAG_O == cmd_ff[CMD_MISS_BIT] ##1 DIAG_O == cmd_ff[CMD_INSTR_BIT];
   endproperty
   a_diag_miss: assert property (p_diag_miss) else $error("diagnostic pin wrong");

   property p_reset_in;
      @(posedge MCLK_I) RST_I |-> !LADDR_OE_O;
   endproperty
   a_reset_in: assert property (p_reset_in) else $error("low lines driven in reset");

   property p_start_addr;
      @(posedge MCLK_I) disable iff (RST_I)
         start |=> ALE_O && AD_OE_O;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("no address phase after start");

   property p_ale_then_data;
      @(posedge MCLK_I) disable iff (RST_I)
         ALE_O |=> in_data && !ALE_O;
   endproperty
   a_ale_then_data: assert property (p_ale_then_data) else $error("data phase missing");

   property p_rd_float;
      @(posedge MCLK_I) disable iff (RST_I)
         (in_data && is_rd) |-> !AD_OE_O;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("bus driven during read data");

   property p_single_low;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && !burst) |-> low_ff == addr_ff[3:0];
   endproperty
   a_single_low: assert property (p_single_low) else $error("first low address wrong");

   property p_burst_start;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && burst) |-> LADDR_O == 4'h0;
   endproperty
   a_burst_start: assert property (p_burst_start) else $error("burst not starting at zero");

   property p_word_port_bits;
      @(posedge MCLK_I) disable iff (RST_I)
         (busy && cmd_ff[CMD_PORT_LSB +: 2] == PORT_32) |-> LADDR_O[1:0] == 2'h0;
   endproperty
   a_word_port_bits: assert property (p_word_port_bits) else $error("low bits on word port");

   property p_half_port_bit;
      @(posedge MCLK_I) disable iff (RST_I)
         (busy && cmd_ff[CMD_PORT_LSB +: 2] == PORT_16) |-> !LADDR_O[0];
   endproperty
   a_half_port_bit: assert property (p_half_port_bit) else $error("bit 0 on halfword port");

   property p_burst_word_len;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && burst && cmd_ff[CMD_PORT_LSB +: 2] == PORT_32) |=> in_data [*4] ##1 !in_data;
   endproperty
   a_burst_word_len: assert property (p_burst_word_len) else $error("word port burst length");

   property p_burst_half_len;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && burst && cmd_ff[CMD_PORT_LSB +: 2] == PORT_16) |=> in_data [*8] ##1 !in_data;
   endproperty
   a_burst_half_len: assert property (p_burst_half_len) else $error("halfword port burst length");

   property p_write_byte_len;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && !is_rd && slog == WORD_LOG && cmd_ff[CMD_PORT_LSB +: 2] == PORT_8)
            |=> in_data [*4] ##1 !in_data;
   endproperty
   a_write_byte_len: assert property (p_write_byte_len) else $error("word write to byte port length");

   property p_single_len;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && kind == KIND_SINGLE && cmd_ff[CMD_PORT_LSB +: 2] == PORT_32) |=> in_data ##1 !in_data;
   endproperty
   a_single_len: assert property (p_single_len) else $error("single read length");

   property p_idle_quiet;
      @(posedge MCLK_I) disable iff (RST_I)
         !busy |-> !ALE_O && !AD_OE_O;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("bus active while idle");

   property p_diag_write;
      @(posedge MCLK_I) disable iff (RST_I)
         (busy && !is_rd) |-> !DIAG_O;
   endproperty
   a_diag_write: assert property (p_diag_write) else $error("diagnostic set on write");

   property p_rd_lane0;
      @(posedge MCLK_I) disable iff (RST_I)
         (in_data && is_rd && pmask[0] && low_ff[3:2] == 2'h0) |=> rbuf_ff[0][7:0] == $past(ad_lane0);
   endproperty
   a_rd_lane0: assert property (p_rd_lane0) else $error("read byte not captured");

   property p_lane_little;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && slog == 2'h0 && !big && !(is_rd && ctrl_ff[CTRL_HOLD_BIT]))
            |-> AD_O[3:0] == ~(4'h1 << addr_ff[1:0]);
   endproperty
   a_lane_little: assert property (p_lane_little) else $error("byte strobe wrong, little order");

   property p_lane_big;
      @(posedge MCLK_I) disable iff (RST_I)
         (ALE_O && slog == 2'h0 && big && !(is_rd && ctrl_ff[CTRL_HOLD_BIT]))
            |-> AD_O[3:0] == ~(4'h8 >> addr_ff[1:0]);
   endproperty
   a_lane_big: assert property (p_lane_big) else $error("byte strobe wrong, big order");

   property p_wdata_stable;
      @(posedge MCLK_I) disable iff (RST_I)
         (in_data && !is_rd && beats_ff != 5'h0) |=> $stable(AD_O);
   endproperty
   a_wdata_stable: assert property (p_wdata_stable) else $error("write data moved between beats");

   property p_strap_hold;
      @(posedge MCLK_I) disable iff (RST_I)
         !RST_I |=> $stable(strap_ff);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("options changed after reset");

   property p_lowlines_out;
      @(posedge MCLK_I) !RST_I |-> LADDR_OE_O;
   endproperty
   a_lowlines_out: assert property (p_lowlines_out) else $error("low lines not driven");
endmodule

/* File: bench/mab_mem_model.sv */
// External memory model: address latch and read data source
`timescale 1ns/100ps
module mab_mem_model (
   // Clock
   input  wire logic        mclk_i,
   // Device side of the shared bus
   input  wire logic [31:0] dev_ad_i,
   input  wire logic        dev_oe_i,
   input  wire logic        ale_i,
   input  wire logic [3:0]  laddr_i,
   // Resolved bus and latched address
   output logic      [31:0] bus_o,
   output logic      [31:0] latch_o
);
   logic [31:0] last_ff = 32'h0;
   logic        seen_ff = 1'b0;
   // Transparent latch, holds through the data phase
   always_latch if (ale_i) latch_o = dev_ad_i;
   // Device drive, else read data, else a changing pattern
   assign bus_o = dev_oe_i ? dev_ad_i : seen_ff ? ({8{laddr_i}} ^ {latch_o[31:4], 4'h0}) : ~last_ff;
   // Last bus level and first strobe seen
   always_ff @(posedge mclk_i) begin
      last_ff <= bus_o;
      seen_ff <= seen_ff | ale_i;
   end
endmodule

/* File: bench/muxed_addr_data_bus_interface_bench.sv */
// Testbench for the muxed address/data bus interface
`timescale 1ns/100ps
module muxed_addr_data_bus_interface_bench;
   import mab_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  av_a = 6'h00;
   logic        av_rd = 1'b0;
   logic        av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [31:0] av_q, ad_o, ad_i, lat, q;
   logic        av_wait, ad_oe, ale, la_oe, diag;
   logic [3:0]  la_o;
   wire  [3:0]  la_w = la_oe ? la_o : 4'ha;
   int          fail_count = 0;
   int          tests_run = 0;
   always #5 mclk = ~mclk;
   mab_bus_if dut (.MCLK_I(mclk), .RST_I(rst), .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
      .AVS_WRITEDATA_I(av_wd), .AVS_READDATA_O(av_q), .AVS_WAITREQUEST_O(av_wait), .AD_I(ad_i), .AD_O(ad_o),
      .AD_OE_O(ad_oe), .ALE_O(ale), .LADDR_I(la_w), .LADDR_O(la_o), .LADDR_OE_O(la_oe), .DIAG_O(diag));
   mab_mem_model mem (.mclk_i(mclk), .dev_ad_i(ad_o), .dev_oe_i(ad_oe), .ale_i(ale), .laddr_i(la_w),
      .bus_o(ad_i), .latch_o(lat));
   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One register access, held until waitrequest is low
   task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      av_a <= a;
      av_wd <= d;
      av_wr <= wr;
      av_rd <= !wr;
      do begin
         @(posedge mclk);
         n++;
      end while (av_wait !== 1'b0 && n < 200);
      r = av_q;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      if (n >= 200) begin
         fail_count++;
         end_of_test();
      end
   endtask
   // Watch one transfer on the pins
   task automatic xfer(input logic [31:0] a, input logic [31:0] wd, input logic [3:0] sb, input int p,
                       input logic rd, input logic bu, input int n, input logic [1:0] dg);
      int w;
      logic [3:0] msk, la;
      w = 0;
      msk = ~(4'(4 >> p) - 4'h1);
      la = bu ? 4'h0 : a[3:0];
      do begin
         @(negedge mclk);
         w++;
      end while (ale !== 1'b1 && w < 20);
      if (w >= 20) begin
         fail_count++;
         end_of_test();
      end
      chk("addr", {a[31:4], sb}, ad_o);
      chk("addr ctl", {29'h0, 2'h3, rd & dg[1]}, {29'h0, ale, ad_oe, diag});
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         chk("data ctl", {25'h0, 1'b0, !rd, la & msk, rd & dg[0]}, {25'h0, ale, ad_oe, la_o, diag});
         if (!rd) chk("wdata", wd, ad_o);
         la = la + 4'(4 >> p);
      end
      @(negedge mclk);
      chk("idle", 32'h0, {30'h0, ale, ad_oe});
      chk("latched", {a[31:4], sb}, lat);
   endtask
   // Read buffer word k after a burst
   function automatic logic [31:0] rbuf_exp(input logic [31:0] a, input int pb, input int k);
      logic [31:0] r;
      logic [3:0]  la;
      for (int b = 0; b < 4; b++) begin
         la = 4'(4 * k + (b & ~(pb - 1)));
         r[8*b +: 8] = 8'(({8{la}} ^ {a[31:4], 4'h0}) >> (8 * b));
      end
      return r;
   endfunction
   // Main sequence
   initial begin
      repeat (16) @(posedge mclk);
      chk("reset pins", 32'h0, {29'h0, la_oe, ale, ad_oe});
      rst <= 1'b0;
      acc(1'b0, OFS_STAT, 32'h0, q);
      chk("straps", 32'ha0, q & 32'hf1);
      for (int p = 0; p < 3; p++) begin
         acc(1'b1, OFS_ADDR, 32'h8765_4328, q);
         acc(1'b1, OFS_WDATA, 32'hdead_beef ^ 32'(p), q);
         acc(1'b1, OFS_CMD, {24'h0, 2'h0, 2'(p), 2'h2, KIND_WRITE}, q);
         xfer(32'h8765_4328, 32'hdead_beef ^ 32'(p), 4'h0, p, 1'b0, 1'b0, 1 << p, 2'h0);
      end
      for (int p = 0; p < 3; p++) begin
         acc(1'b1, OFS_ADDR, 32'h1357_9bd4, q);
         acc(1'b1, OFS_CMD, {24'h0, 1'b1, p == 1, 2'(p), 2'h2, KIND_BURST}, q);
         xfer(32'h1357_9bd4, 32'h0, 4'h0, p, 1'b1, 1'b1, 4 << p, {1'b1, p == 1});
         for (int k = 0; k < 4; k++) begin
            acc(1'b0, OFS_RBUF + 6'(4 * k), 32'h0, q);
            chk("rbuf", rbuf_exp(32'h1357_9bd4, 4 >> p, k), q);
         end
      end
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, OFS_CTRL, 32'(c), q);
         acc(1'b1, OFS_ADDR, 32'h2468_ace1, q);
         acc(1'b1, OFS_CMD, {24'h0, 2'h1, 2'h0, 2'h0, KIND_SINGLE}, q);
         xfer(32'h2468_ace1, 32'h0, c[0] ? 4'hf : c[1] ? 4'hb : 4'hd, 0, 1'b1, 1'b0, 1, 2'h1);
      end
      acc(1'b1, OFS_CTRL, 32'h2, q);
      acc(1'b1, OFS_ADDR, 32'h2468_ace2, q);
      acc(1'b1, OFS_CMD, {24'h0, 2'h2, PORT_16, 2'h1, KIND_SINGLE}, q);
      xfer(32'h2468_ace2, 32'h0, 4'hc, 1, 1'b1, 1'b0, 1, 2'h2);
      acc(1'b0, OFS_RBUF, 32'h0, q);
      chk("rbuf half", 32'h2468_8ec2, q);
      acc(1'b0, 6'h3c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      end_of_test();
   end
endmodule
